// file: rtl/vic_regs.vh
// Constants for the vectored interrupt controller: vectors, field positions,
// reset values and the source numbering used by the top and its flag cells.
// Assumes a core that presents T2 phase pulses and stack status as plain ports.
// Contract
// - Global enable low blocks all servicing
// - Vector only with global, own enable, flag
// - Accept pushes next address, loads vector
// - Return instruction pops saved address
// - Entry clears global enable automatically
// - Blocked requests still set and hold flags
// - Full stack holds off acknowledge
// - Requests sampled at next T2 phase pulse
// - Fixed priority external down to multifunction
// - External falling edge sets flag, vector 04h
// - Servicing clears source flag with global
// - Timer overflows set flags, vectors 08h 0ch
// - Peripheral events set flag, vector 10h
// - RTC timeout sets flag, vector 14h
// - Multifunction events set flag, vector 18h
// - Flag holds until serviced or cleared
// - Any enabled source wakes from power down
// - Only program counter saved by hardware
// - FSK data enable masks mark, raw, carrier
// - Reset leaves all interrupts disabled
`ifndef VIC_REGS_VH
`define VIC_REGS_VH

`define VIC_PC_W 14
`define VIC_NSRC 6
// Source index, also priority order (0 highest)
`define VIC_SRC_EXT 0
`define VIC_SRC_TA 1
`define VIC_SRC_TB 2
`define VIC_SRC_PER 3
`define VIC_SRC_RTC 4
`define VIC_SRC_MF 5
`define VIC_VEC_EXT 14'h0004
`define VIC_VEC_TA 14'h0008
`define VIC_VEC_TB 14'h000c
`define VIC_VEC_PER 14'h0010
`define VIC_VEC_RTC 14'h0014
`define VIC_VEC_MF 14'h0018
// Peripheral sub-source bits
`define VIC_PER_W 5
`define VIC_PER_TONE 0
`define VIC_PER_RING 1
`define VIC_PER_CARR 2
`define VIC_PER_PKT 3
`define VIC_PER_RAW 4
// Multi-function sub-source bits
`define VIC_MF_W 6
`define VIC_MF_C0 0
`define VIC_MF_C5 1
`define VIC_MF_C7 2
`define VIC_MF_SER 3
`define VIC_MF_XPF 4
`define VIC_MF_TMC 5
`define VIC_EN_RST 6'h00
`define VIC_PER_EN_RST 5'h00
`define VIC_MF_EN_RST 6'h00

`endif

// file: rtl/vic_flag.v
// One sticky request flag with hardware set, service clear and software
// clear. Assumes all inputs are synchronous single-cycle pulses or levels.
`timescale 1ns/1ps
`include "vic_regs.vh"
module vic_flag
(
    input wire clk,
    input wire resetn,
    input wire set_evt,
    input wire svc_clr,
    input wire sw_clr,
    input wire sw_set,
    output reg flag_q
);
    // Set wins over either clear so that an event is never lost
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            flag_q <= 1'b0;
        else if (set_evt || sw_set)
            flag_q <= 1'b1;
        else if (svc_clr || sw_clr)
            flag_q <= 1'b0;
    end
endmodule

// file: rtl/vic_top.v
// Vectored interrupt controller top: edge capture, sub-source gating, sticky
// flags, T2-phase sampled fixed-priority arbitration and the call/return
// handshake to the core's program counter sequencer.
// Assumes all inputs are synchronous to clk and the core executes vec_call_q.
`timescale 1ns/1ps
`include "vic_regs.vh"
module vic_top
#(
    parameter PC_W = `VIC_PC_W
)
(
    input wire clk,
    input wire resetn,
    // Core timing and stack status
    input wire second_clock_phase,
    input wire stack_full,
    input wire [PC_W-1:0] next_pc,
    input wire return_from_irq_instr,
    input wire [PC_W-1:0] stack_top_pc,
    // Software control of enables
    input wire global_enable_set,
    input wire global_enable_clr,
    input wire [`VIC_NSRC-1:0] src_enable_wdata,
    input wire src_enable_we,
    input wire [`VIC_PER_W-1:0] per_enable_wdata,
    input wire per_enable_we,
    input wire [`VIC_MF_W-1:0] mf_enable_wdata,
    input wire mf_enable_we,
    input wire fsk_data_irq_enable,
    // Software flag access (clear or set per bit)
    input wire [`VIC_NSRC-1:0] flag_sw_clr,
    input wire [`VIC_NSRC-1:0] flag_sw_set,
    input wire [`VIC_PER_W-1:0] per_sub_sw_clr,
    input wire [`VIC_MF_W-1:0] mf_sub_sw_clr,
    // Event sources
    input wire ext_irq_pin,
    input wire timer_a_ovf,
    input wire timer_b_ovf,
    input wire tone_valid,
    input wire ring_detect,
    input wire fsk_carrier,
    input wire fsk_packet_ready,
    input wire fsk_raw_data,
    input wire rtc_timeout,
    input wire port_c_bit_zero,
    input wire port_c_bit_five,
    input wire port_c_bit_seven,
    input wire serial_irq,
    input wire ext_periph_pin,
    input wire timer_c_ovf,
    // Status
    output reg global_irq_enable,
    output reg [`VIC_NSRC-1:0] src_enable_q,
    output reg [`VIC_NSRC-1:0] src_flag_q,
    output reg [`VIC_PER_W-1:0] per_sub_flag_q,
    output reg [`VIC_MF_W-1:0] mf_sub_flag_q,
    output reg [`VIC_PER_W-1:0] per_enable_q,
    output reg [`VIC_MF_W-1:0] mf_enable_q,
    // Core sequencing
    output reg vec_call_q,
    output reg [PC_W-1:0] vec_addr_q,
    output reg stack_push_q,
    output reg [PC_W-1:0] push_pc_q,
    output reg stack_pop_q,
    output reg [PC_W-1:0] pc_load_q,
    output reg pc_load_en_q,
    output reg wake_q
);
    localparam ST_IDLE = 2'b01;
    localparam ST_CALL = 2'b10;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg t2_prev_q;
    reg ext_prev_q;
    reg raw_prev_q;
    reg c0_prev_q;
    reg c5_prev_q;
    reg c7_prev_q;
    reg xpf_prev_q;
    reg [`VIC_NSRC-1:0] sampled_q;
    wire [`VIC_NSRC-1:0] flags;
    wire [`VIC_NSRC-1:0] set_evt;
    wire [`VIC_NSRC-1:0] svc_clr;
    wire t2_rise;
    wire [`VIC_PER_W-1:0] per_evt;
    wire [`VIC_MF_W-1:0] mf_evt;
    wire [`VIC_PER_W-1:0] per_gate;
    wire [`VIC_PER_W-1:0] per_sub_d;
    wire [`VIC_MF_W-1:0] mf_sub_d;
    reg [`VIC_NSRC-1:0] grant;
    reg [PC_W-1:0] grant_vec;
    reg [`VIC_NSRC-1:0] grant_q;
    wire [`VIC_NSRC-1:0] pend;
    wire accept;
    integer i;

    assign t2_rise = second_clock_phase & ~t2_prev_q;

    // Edge detection on the pins and raw data
    // Pins reset to their idle levels so release gives no false edge
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            t2_prev_q <= 1'b0;
            ext_prev_q <= 1'b1;
            raw_prev_q <= 1'b1;
            c0_prev_q <= 1'b1;
            c5_prev_q <= 1'b1;
            c7_prev_q <= 1'b0;
            xpf_prev_q <= 1'b1;
        end
        else
        begin
            t2_prev_q <= second_clock_phase;
            ext_prev_q <= ext_irq_pin;
            raw_prev_q <= fsk_raw_data;
            c0_prev_q <= port_c_bit_zero;
            c5_prev_q <= port_c_bit_five;
            c7_prev_q <= port_c_bit_seven;
            xpf_prev_q <= ext_periph_pin;
        end
    end

    assign per_evt[`VIC_PER_TONE] = tone_valid;
    assign per_evt[`VIC_PER_RING] = ring_detect;
    assign per_evt[`VIC_PER_CARR] = fsk_carrier;
    assign per_evt[`VIC_PER_PKT] = fsk_packet_ready;
    assign per_evt[`VIC_PER_RAW] = raw_prev_q & ~fsk_raw_data;
    assign mf_evt[`VIC_MF_C0] = c0_prev_q & ~port_c_bit_zero;
    assign mf_evt[`VIC_MF_C5] = c5_prev_q & ~port_c_bit_five;
    assign mf_evt[`VIC_MF_C7] = ~c7_prev_q & port_c_bit_seven;
    assign mf_evt[`VIC_MF_SER] = serial_irq;
    assign mf_evt[`VIC_MF_XPF] = xpf_prev_q & ~ext_periph_pin;
    assign mf_evt[`VIC_MF_TMC] = timer_c_ovf;

    // FSK data mode suppresses the carrier and raw sub-sources; the mark
    // indication rides on the carrier bit here
    assign per_gate = per_enable_q & ~({`VIC_PER_W{fsk_data_irq_enable}}
        & ((5'h01 << `VIC_PER_CARR) | (5'h01 << `VIC_PER_RAW)));

    assign per_sub_d = (per_sub_flag_q & ~per_sub_sw_clr) | per_evt;
    assign mf_sub_d = (mf_sub_flag_q & ~mf_sub_sw_clr) | mf_evt;

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            per_sub_flag_q <= {`VIC_PER_W{1'b0}};
            mf_sub_flag_q <= {`VIC_MF_W{1'b0}};
        end
        else
        begin
            per_sub_flag_q <= per_sub_d;
            mf_sub_flag_q <= mf_sub_d;
        end
    end

    assign set_evt[`VIC_SRC_EXT] = ext_prev_q & ~ext_irq_pin;
    assign set_evt[`VIC_SRC_TA] = timer_a_ovf;
    assign set_evt[`VIC_SRC_TB] = timer_b_ovf;
    assign set_evt[`VIC_SRC_PER] = |(per_evt & per_gate);
    assign set_evt[`VIC_SRC_RTC] = rtc_timeout;
    assign set_evt[`VIC_SRC_MF] = |(mf_evt & mf_enable_q);

    // Only the source latched at acceptance is cleared, in the call cycle
    assign svc_clr = (state_q == ST_CALL) ? grant_q
        : {`VIC_NSRC{1'b0}};

    // One sticky flag per source; inside the cell a set beats a clear
    genvar g;
    generate
        for (g = 0; g < `VIC_NSRC; g = g + 1)
        begin : flag_gen
            vic_flag u_flag
            (
                .clk(clk),
                .resetn(resetn),
                .set_evt(set_evt[g]),
                .svc_clr(svc_clr[g]),
                .sw_clr(flag_sw_clr[g]),
                .sw_set(flag_sw_set[g]),
                .flag_q(flags[g])
            );
        end
    endgenerate

    // Requests between two T2 rising edges are taken at the second one
    // The losers of a call are dropped here and sampled at the next rise
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            sampled_q <= {`VIC_NSRC{1'b0}};
        else if (t2_rise)
            sampled_q <= flags & src_enable_q;
        else if (state_q == ST_CALL)
            sampled_q <= {`VIC_NSRC{1'b0}};
    end

    // A snapshot only counts while its flag and enable still stand, so a
    // disable or software clear after the T2 sample cannot cause a call
    assign pend = sampled_q & flags & src_enable_q;

    // Lowest index wins
    always @*
    begin
        grant = {`VIC_NSRC{1'b0}};
        grant_vec = {PC_W{1'b0}};
        for (i = `VIC_NSRC - 1; i >= 0; i = i - 1)
        begin
            if (pend[i])
            begin
                grant = {`VIC_NSRC{1'b0}};
                grant[i] = 1'b1;
            end
        end
        case (grant)
            6'h01: grant_vec = `VIC_VEC_EXT;
            6'h02: grant_vec = `VIC_VEC_TA;
            6'h04: grant_vec = `VIC_VEC_TB;
            6'h08: grant_vec = `VIC_VEC_PER;
            6'h10: grant_vec = `VIC_VEC_RTC;
            6'h20: grant_vec = `VIC_VEC_MF;
            default: grant_vec = {PC_W{1'b0}};
        endcase
    end

    // Acceptance waits out a T2 rise so that a fresh sample is never
    // overtaken by the one it replaces
    assign accept = global_irq_enable && (|pend) && !stack_full
        && !t2_rise;

    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
                // Acceptance needs global enable, a sampled enabled flag and
                // room on the stack
                if (accept)
                    state_d = ST_CALL;
            ST_CALL:
                state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    // Control bits written by software; reset leaves every source
    // disabled until software enables it
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            src_enable_q <= `VIC_EN_RST;
            per_enable_q <= `VIC_PER_EN_RST;
            mf_enable_q <= `VIC_MF_EN_RST;
        end
        else
        begin
            if (src_enable_we)
                src_enable_q <= src_enable_wdata;
            if (per_enable_we)
                per_enable_q <= per_enable_wdata;
            if (mf_enable_we)
                mf_enable_q <= mf_enable_wdata;
        end
    end

    // Entry clears the global enable ahead of a software set in the same
    // cycle, so a late set cannot let a second source nest
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            global_irq_enable <= 1'b0;
        else if (state_d == ST_CALL)
            global_irq_enable <= 1'b0;
        else if (global_enable_set)
            global_irq_enable <= 1'b1;
        else if (global_enable_clr)
            global_irq_enable <= 1'b0;
    end

    // The winner is held for the call cycle so that only its flag is
    // cleared even if enables change meanwhile
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            grant_q <= {`VIC_NSRC{1'b0}};
        else if (state_d == ST_CALL)
            grant_q <= grant;
    end

    // Call and return share the load path; a call in the same cycle wins
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= ST_IDLE;
            vec_call_q <= 1'b0;
            vec_addr_q <= {PC_W{1'b0}};
            stack_push_q <= 1'b0;
            push_pc_q <= {PC_W{1'b0}};
            stack_pop_q <= 1'b0;
            pc_load_q <= {PC_W{1'b0}};
            pc_load_en_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            vec_call_q <= (state_d == ST_CALL);
            stack_push_q <= (state_d == ST_CALL);
            stack_pop_q <= return_from_irq_instr;
            pc_load_en_q <= (state_d == ST_CALL) || return_from_irq_instr;
            if (state_d == ST_CALL)
            begin
                // Only the program counter is saved; accumulator and status
                // are left to the service routine
                vec_addr_q <= grant_vec;
                push_pc_q <= next_pc;
                pc_load_q <= grant_vec;
            end
            else if (return_from_irq_instr)
                pc_load_q <= stack_top_pc;
        end
    end

    // Status view; wake ignores the global enable so any flagged source
    // with its own enable set rouses the core
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            src_flag_q <= {`VIC_NSRC{1'b0}};
            wake_q <= 1'b0;
        end
        else
        begin
            src_flag_q <= flags;
            wake_q <= |(flags & src_enable_q);
        end
    end
endmodule

// file: tb/vic_checker.sv
// Assertions on the interrupt controller top, bound to it.
// Assumes it sees only the top's ports, one clock domain.
`timescale 1ns/1ps
module vic_checker
#(
    parameter PC_W = 14
)
(
    input wire clk,
    input wire resetn,
    input wire stack_full,
    input wire [PC_W-1:0] stack_top_pc,
    input wire return_from_irq_instr,
    input wire global_enable_set,
    input wire [5:0] flag_sw_clr,
    input wire global_irq_enable,
    input wire [5:0] src_flag_q,
    input wire vec_call_q,
    input wire [PC_W-1:0] vec_addr_q,
    input wire stack_push_q,
    input wire stack_pop_q,
    input wire [PC_W-1:0] pc_load_q,
    input wire pc_load_en_q
);
    // Vector 04h maps to source 0, each further vector is 4 higher
    wire [2:0] vidx = vec_addr_q[4:2] - 3'd1;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    global_gate_a:
        assert property (vec_call_q |-> $past(global_irq_enable))
        else $error("call while global enable was off");
    full_hold_a:
        assert property (vec_call_q |-> !$past(stack_full))
        else $error("call while stack was full");
    entry_clear_a:
        assert property (vec_call_q && !$past(global_enable_set)
            |-> !global_irq_enable)
        else $error("global enable kept on entry");
    call_push_a:
        assert property (vec_call_q |-> stack_push_q && pc_load_en_q)
        else $error("call without push and load");
    one_call_a:
        assert property (vec_call_q |=> !vec_call_q)
        else $error("call longer than one cycle");
    flag_clear_a:
        assert property (vec_call_q |-> ##[1:2] !src_flag_q[vidx])
        else $error("serviced flag not cleared");
    ret_pop_a:
        assert property (return_from_irq_instr |=> stack_pop_q
            && pc_load_en_q && pc_load_q == $past(stack_top_pc))
        else $error("return did not pop saved address");
    // A service drop shows on the status two cycles after the call pulse
    flag_sticky_a:
        assert property (|($past(src_flag_q) & ~src_flag_q)
            |-> $past(vec_call_q, 2) || |$past(flag_sw_clr)
            || |$past(flag_sw_clr, 2))
        else $error("flag dropped without service or clear");
endmodule
bind vic_top vic_checker #(.PC_W(PC_W)) vic_checker_i (.clk(clk),
    .resetn(resetn), .stack_full(stack_full), .stack_top_pc(stack_top_pc),
    .return_from_irq_instr(return_from_irq_instr),
    .global_enable_set(global_enable_set), .flag_sw_clr(flag_sw_clr),
    .global_irq_enable(global_irq_enable), .src_flag_q(src_flag_q),
    .vec_call_q(vec_call_q), .vec_addr_q(vec_addr_q),
    .stack_push_q(stack_push_q), .stack_pop_q(stack_pop_q),
    .pc_load_q(pc_load_q), .pc_load_en_q(pc_load_en_q));

// file: tb/vic_core_model.sv
// Core side model: phase pulses, stack status, next address and returns.
// Assumes the bench asks for returns and a full stack on its inputs.
`timescale 1ns/1ps
module vic_core_model
#(
    parameter PC_W = 14,
    parameter NEXT_PC = 14'h0123
)
(
    input wire clk,
    input wire resetn,
    input wire ret_req,
    input wire full_req,
    input wire stack_push_q,
    input wire [PC_W-1:0] push_pc_q,
    output reg second_clock_phase,
    output wire stack_full,
    output wire [PC_W-1:0] next_pc,
    output reg [PC_W-1:0] stack_top_pc,
    output reg return_from_irq_instr
);
    reg [1:0] ph_q;
    assign stack_full = full_req;
    assign next_pc = NEXT_PC;
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ph_q <= 2'h0;
            second_clock_phase <= 1'b0;
            stack_top_pc <= {PC_W{1'b0}};
            return_from_irq_instr <= 1'b0;
        end
        else
        begin
            ph_q <= ph_q + 2'h1;
            second_clock_phase <= ph_q[1];
            return_from_irq_instr <= ret_req;
            // Only the address is kept, nothing else of the core state
            if (stack_push_q)
                stack_top_pc <= push_pc_q;
        end
    end
endmodule

// file: tb/vic_top_bench.sv
// Bench for the interrupt controller top, core model on its far side.
// Assumes the core model makes phase pulses, stack status and returns.
`timescale 1ns/1ps
module vic_top_bench;
    localparam [13:0] NPC = 14'h0123;
    localparam [16:0] ALL = 17'h1ffff;
    // Source index of each event input, three bits per event
    localparam [44:0] SRC = 45'h16db6c6db688;
    reg clk = 1'b0, resetn = 1'b0, gset = 1'b0, swe = 1'b0, fskd = 1'b0;
    reg ret_req = 1'b0, full_req = 1'b0;
    reg [5:0] swd = 6'h00, mwd = 6'h00, fclr = 6'h00, fset = 6'h00;
    reg [4:0] pwd = 5'h00;
    reg [14:0] ev = 15'h2681;
    integer fails = 0, n_compared = 0, ncall = 0, i, n;
    wire t2, sfull, ret, vcall, push, pop, ld_en, wake, gen;
    wire [13:0] npc, top, vaddr, ppc, ld_pc;
    wire [5:0] sen, flg, mfe, msf;
    wire [4:0] pere, psf;
    vic_core_model vic_core_model_i (.clk(clk), .resetn(resetn),
        .ret_req(ret_req), .full_req(full_req), .stack_push_q(push),
        .push_pc_q(ppc), .second_clock_phase(t2), .stack_full(sfull),
        .next_pc(npc), .stack_top_pc(top), .return_from_irq_instr(ret));
    vic_top vic_top_i (.clk(clk), .resetn(resetn), .second_clock_phase(t2),
        .stack_full(sfull), .next_pc(npc), .return_from_irq_instr(ret),
        .stack_top_pc(top), .global_enable_set(gset),
        .global_enable_clr(1'b0), .src_enable_wdata(swd),
        .src_enable_we(swe), .per_enable_wdata(pwd), .per_enable_we(swe),
        .mf_enable_wdata(mwd), .mf_enable_we(swe),
        .fsk_data_irq_enable(fskd), .flag_sw_clr(fclr), .flag_sw_set(fset),
        .per_sub_sw_clr(5'h00), .mf_sub_sw_clr(6'h00), .ext_irq_pin(ev[0]),
        .timer_a_ovf(ev[1]), .timer_b_ovf(ev[2]), .tone_valid(ev[3]),
        .ring_detect(ev[4]), .fsk_carrier(ev[5]), .fsk_packet_ready(ev[6]),
        .fsk_raw_data(ev[7]), .rtc_timeout(ev[8]), .port_c_bit_zero(ev[9]),
        .port_c_bit_five(ev[10]), .port_c_bit_seven(ev[11]),
        .serial_irq(ev[12]), .ext_periph_pin(ev[13]), .timer_c_ovf(ev[14]),
        .global_irq_enable(gen), .src_enable_q(sen), .src_flag_q(flg),
        .per_sub_flag_q(psf), .mf_sub_flag_q(msf), .per_enable_q(pere),
        .mf_enable_q(mfe), .vec_call_q(vcall), .vec_addr_q(vaddr),
        .stack_push_q(push), .push_pc_q(ppc), .stack_pop_q(pop),
        .pc_load_q(ld_pc), .pc_load_en_q(ld_en), .wake_q(wake));
    initial forever #5 clk = ~clk;
    always @(posedge clk)
        if (vcall === 1'b1)
            ncall = ncall + 1;
    task chk(input [19:0] seen, input [19:0] exp);
    begin
        n_compared = n_compared + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask
    task tick(input integer k);
        repeat (k) @(posedge clk);
    endtask
    // Enable write data, enable strobe, global set, flag set and clear
    task pulse(input [16:0] wd, input we, input g, input [5:0] fs,
        input [5:0] fc);
    begin
        tick(1);
        {swd, pwd, mwd} <= wd;
        swe <= we;
        gset <= g;
        fset <= fs;
        fclr <= fc;
        tick(1);
        swe <= 1'b0;
        gset <= 1'b0;
        fset <= 6'h00;
        fclr <= 6'h00;
    end
    endtask
    // Two toggles give exactly one active edge whatever the idle level
    task evt(input integer k, input [5:0] exp);
    begin
        tick(1);
        ev[k] <= ~ev[k];
        tick(1);
        ev[k] <= ~ev[k];
        tick(4);
        #1;
        chk(flg, exp);
    end
    endtask
    task wait_call(input [19:0] exp);
    begin
        n = 0;
        while (vcall !== 1'b1 && n < 60)
        begin
            tick(1);
            #1;
            n = n + 1;
        end
        chk({vcall, vaddr}, {1'b1, exp[13:0]});
    end
    endtask
    task no_call(input integer k);
    begin
        n = ncall;
        tick(k);
        #1;
        chk(ncall[19:0] - n[19:0], 20'h0);
    end
    endtask
    task give_verdict;
    begin
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask
    initial
    begin
        #200000;
        fails = fails + 1;
        give_verdict;
    end
    initial
    begin
        tick(12);
        resetn <= 1'b1;
        tick(1);
        #1;
        chk({gen, sen, pere, mfe, wake}, 20'h0);
        pulse(ALL, 1'b1, 1'b0, 6'h00, 6'h00);
        for (i = 0; i < 15; i = i + 1)
        begin
            pulse(ALL, 1'b0, 1'b0, 6'h00, 6'h3f);
            evt(i, 6'h01 << SRC[3*i +: 3]);
            chk(wake, 1'b1);
        end
        tick(1);
        fskd <= 1'b1;
        pulse(ALL, 1'b0, 1'b0, 6'h00, 6'h3f);
        evt(5, 6'h00);
        evt(7, 6'h00);
        pulse(17'h1f83f, 1'b1, 1'b0, 6'h00, 6'h00);
        evt(3, 6'h00);
        chk({psf, msf}, 20'h007ff);
        $display("test events done");
        pulse(ALL, 1'b1, 1'b0, 6'h02, 6'h00);
        no_call(20);
        chk(flg, 6'h02);
        pulse(17'h007ff, 1'b1, 1'b1, 6'h00, 6'h00);
        no_call(20);
        pulse(ALL, 1'b1, 1'b0, 6'h00, 6'h00);
        wait_call(20'h00008);
        chk(ppc, NPC);
        tick(2);
        #1;
        chk({gen, flg}, 20'h0);
        tick(1);
        ret_req <= 1'b1;
        tick(1);
        ret_req <= 1'b0;
        tick(1);
        #1;
        chk({pop, ld_en, ld_pc}, {2'b11, NPC});
        $display("test call and return done");
        tick(1);
        full_req <= 1'b1;
        pulse(ALL, 1'b0, 1'b1, 6'h10, 6'h00);
        no_call(20);
        chk(flg, 6'h10);
        tick(1);
        full_req <= 1'b0;
        wait_call(20'h00014);
        $display("test full stack done");
        pulse(ALL, 1'b0, 1'b0, 6'h3f, 6'h00);
        for (i = 1; i < 7; i = i + 1)
        begin
            pulse(ALL, 1'b0, 1'b1, 6'h00, 6'h00);
            wait_call({i[3:0], 2'b00});
        end
        $display("test priority done");
        give_verdict;
    end
endmodule
